// [src/mpp_top.sv]
/*
  Measurement post-processing: two-channel spike filter, thickness,
  statistics, mastering with timeout, material table and output routing.
  Assumes upstream delivers one-cycle valid strobes with both channels,
  an AXI4-Lite master for configuration, and downstream always ready.
*/
// How it works
// - Each new value compared against mean of recent valid readings.
// - Mean window length configurable from one to ten values.
// - Correct when deviation exceeds tolerance band either side.
// - An outlier is replaced with the preceding output value.
// - Consecutive corrections capped at configured count up to 127.
// - Successive outliers corrected from the previously corrected value.
// - Both channels filtered alike; thickness uses corrected distances.
// - Statistics use only values from the current evaluation cycle.
// - Statistics give min, max and peak-to-peak over selected count.
// - Statistics restart discards accumulated values, starts fresh cycle.
// - Mastering shifts later outputs so captured value reads master value.
// - Zero-setting is mastering with master value zero.
// - Master waits up to two seconds for next valid value.
// - No value in time: abandon, report timeout code, offset unchanged.
// - Master reset clears the offset while the master sequencer is idle.
// - Offset applies to the digital outputs.
// - Twenty refractive index entries, restored on factory reset.
// - Selected material index is presented to the distance calculation.
// - Output goes to at most one selected interface.
// - Item enable mask passed out on out_items; every data output driven each sample.
// - Serial rate selectable, including 9.6, 115.2 and 4000 kBps.
`timescale 1ns/1ns
`include "mpp_defines.svh"
module mpp_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Measurement stream in
  input wire logic meas_valid,
  input wire logic meas_err,
  input wire logic [31:0] meas_d0,
  input wire logic [31:0] meas_d1,
  // Measurement stream out, one interface at a time
  output logic eth_valid,
  output logic ser_valid,
  output logic [31:0] out_d0,
  output logic [31:0] out_d1,
  output logic [31:0] out_thick,
  output logic out_err,
  output logic [7:0] out_items,
  output logic [2:0] ser_baud,
  // To distance calculation
  output logic [31:0] refr_index
);
  logic [31:0] ctrl_r, spike_r, master_r, offset_r, matidx_r, stmin_r, stmax_r;
  logic [14:0] statlen_r, statcnt_r;
  logic [4:0] matsel_r;
  logic [31:0] mat_r [0:19];
  logic [7:0] err_code_r;
  logic [31:0] wait_r;
  logic aw_hold_r, w_hold_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_go, cmd_stat, cmd_master, cmd_zero, cmd_mreset, cmd_factory;
  logic zero_mode_r;
  logic stat_fresh_r;
  logic meas_err_d_r;
  mpp_pkg::mpp_mst_t mst_r;
  mpp_spike_if ch0 ();
  mpp_spike_if ch1 ();

  // Byte-enable merge used by every writable register except the material selection and the command register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = d[i*8 +: 8];
    end
    return r;
  endfunction : merge

  // Write channel: address and data captured in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= '0;
      wstrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      s_axi_awready <= !aw_hold_r && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
      s_axi_wready <= !w_hold_r && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_r > `MPP_MATVAL_OFF || awaddr_r[1:0] != 2'b00)
          ? 2'b10 : 2'b00;
      end else if (s_axi_bready && s_axi_bvalid) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;
  // Command strobes, one cycle
  assign cmd_stat = wr_go && awaddr_r == `MPP_CMD_OFF && wdata_r[`MPP_CMD_STAT_RST];
  assign cmd_master = wr_go && awaddr_r == `MPP_CMD_OFF && wdata_r[`MPP_CMD_MASTER];
  assign cmd_zero = wr_go && awaddr_r == `MPP_CMD_OFF && wdata_r[`MPP_CMD_ZERO];
  assign cmd_mreset = wr_go && awaddr_r == `MPP_CMD_OFF && wdata_r[`MPP_CMD_MRESET];
  assign cmd_factory = wr_go && awaddr_r == `MPP_CMD_OFF && wdata_r[`MPP_CMD_FACTORY];

  // Configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= `MPP_CTRL_RST;
      spike_r <= `MPP_SPIKE_RST;
      statlen_r <= `MPP_STATLEN_RST;
      master_r <= '0;
      matsel_r <= 5'h00;
      matidx_r <= '0;
    end else if (wr_go) begin
      case (awaddr_r)
        `MPP_CTRL_OFF: ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r);
        `MPP_SPIKE_OFF: spike_r <= merge(spike_r, wdata_r, wstrb_r);
        `MPP_STATLEN_OFF: statlen_r <= 15'(merge({17'h0, statlen_r}, wdata_r, wstrb_r));
        `MPP_MASTER_OFF: master_r <= merge(master_r, wdata_r, wstrb_r);
        `MPP_MATSEL_OFF: matsel_r <= (wdata_r[4:0] < 5'd20) ? wdata_r[4:0] : matsel_r;
        `MPP_MATIDX_OFF: matidx_r <= merge(matidx_r, wdata_r, wstrb_r);
        default: ;
      endcase
    end
  end

  // Material table; factory reset reloads the default index everywhere
  always_ff @(posedge aclk) begin
    if (!aresetn || cmd_factory) begin
      for (int i = 0; i < `MPP_MAT_N; i++) mat_r[i] <= `MPP_IDX_DEF;
    end else if (wr_go && awaddr_r == `MPP_MATVAL_OFF && matsel_r < 5'd20) begin
      mat_r[matsel_r] <= merge(mat_r[matsel_r], wdata_r, wstrb_r);
    end
  end

  // Selected refractive index goes back to the distance calculation
  always_ff @(posedge aclk) begin
    if (!aresetn) refr_index <= `MPP_IDX_DEF;
    else refr_index <= mat_r[matidx_r[4:0] < 5'd20 ? matidx_r[4:0] : 5'h00];
  end

  // Both channels pass through identical filters
  assign ch0.in_valid = meas_valid;
  assign ch0.in_err = meas_err;
  assign ch0.in_val = meas_d0;
  assign ch1.in_valid = meas_valid;
  assign ch1.in_err = meas_err;
  assign ch1.in_val = meas_d1;
  mpp_spike u_sp0 (.aclk(aclk), .aresetn(aresetn), .enable(ctrl_r[`MPP_CTRL_SPIKE_EN]),
    .eval_len(spike_r[3:0]), .tol({24'h0, spike_r[15:8]}), .corr_max(spike_r[22:16]),
    .s(ch0));
  mpp_spike u_sp1 (.aclk(aclk), .aresetn(aresetn), .enable(ctrl_r[`MPP_CTRL_SPIKE_EN]),
    .eval_len(spike_r[3:0]), .tol({24'h0, spike_r[15:8]}), .corr_max(spike_r[22:16]),
    .s(ch1));

  // Master sequencer with two-second wait
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mst_r <= mpp_pkg::MPP_M_IDLE;
      wait_r <= '0;
      offset_r <= '0;
      zero_mode_r <= 1'b0;
      err_code_r <= 8'h00;
    end else begin
      case (mst_r)
        mpp_pkg::MPP_M_IDLE: begin
          if (cmd_mreset) offset_r <= '0;
          if (cmd_master || cmd_zero) begin
            mst_r <= mpp_pkg::MPP_M_WAIT;
            zero_mode_r <= cmd_zero;
            wait_r <= '0;
            err_code_r <= 8'h00;
          end
        end
        mpp_pkg::MPP_M_WAIT: begin
          wait_r <= wait_r + 32'h0000_0001;
          if (ch0.out_valid && !meas_err_d_r) begin
            offset_r <= (zero_mode_r ? 32'h0000_0000 : master_r) - ch0.out_val;
            mst_r <= mpp_pkg::MPP_M_DONE;
          end else if (wait_r >= 32'(`MPP_MASTER_WAIT_CYC) - 32'h0000_0001) begin
            err_code_r <= `MPP_TIMEOUT_CODE;
            mst_r <= mpp_pkg::MPP_M_IDLE;
          end
        end
        mpp_pkg::MPP_M_DONE: mst_r <= mpp_pkg::MPP_M_IDLE;
        default: mst_r <= mpp_pkg::MPP_M_IDLE;
      endcase
    end
  end

  // Error flag aligned to filter output
  always_ff @(posedge aclk) begin
    if (!aresetn) meas_err_d_r <= 1'b0;
    else meas_err_d_r <= meas_err;
  end

  // Statistics over current cycle; restart wins over a sample
  logic signed [31:0] smp;
  assign smp = ch0.out_val + offset_r;
  always_ff @(posedge aclk) begin
    if (!aresetn || cmd_stat) begin
      stmin_r <= '0;
      stmax_r <= '0;
      statcnt_r <= 15'h0000;
      stat_fresh_r <= 1'b1;
    end else if (ch0.out_valid && !meas_err_d_r) begin
      // Window ends after the selected count, next value opens a new one
      if (stat_fresh_r || statcnt_r >= statlen_r) begin
        stmin_r <= smp;
        stmax_r <= smp;
        statcnt_r <= 15'h0001;
        stat_fresh_r <= 1'b0;
      end else begin
        if (smp < $signed(stmin_r)) stmin_r <= smp;
        if (smp > $signed(stmax_r)) stmax_r <= smp;
        statcnt_r <= statcnt_r + 15'h0001;
      end
    end
  end

  // Output stage: offset applied, one interface strobed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      eth_valid <= 1'b0;
      ser_valid <= 1'b0;
      out_d0 <= '0;
      out_d1 <= '0;
      out_thick <= '0;
      out_err <= 1'b0;
      out_items <= 8'h00;
      ser_baud <= 3'h0;
    end else begin
      eth_valid <= ch0.out_valid && ctrl_r[5:4] == mpp_pkg::MPP_IF_ETH;
      ser_valid <= ch0.out_valid && ctrl_r[5:4] == mpp_pkg::MPP_IF_SER;
      out_d0 <= ch0.out_val + offset_r;
      out_d1 <= ch1.out_val + offset_r;
      out_thick <= ch1.out_val - ch0.out_val;
      out_err <= meas_err_d_r;
      out_items <= ctrl_r[`MPP_CTRL_ITEMS_LO +: 8];
      ser_baud <= ctrl_r[`MPP_CTRL_BAUD_LO +: 3];
    end
  end

  // Read channel, one wait cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        case (s_axi_araddr)
          `MPP_CTRL_OFF: s_axi_rdata <= ctrl_r;
          `MPP_SPIKE_OFF: s_axi_rdata <= spike_r;
          `MPP_STATLEN_OFF: s_axi_rdata <= {17'h0, statlen_r};
          `MPP_MASTER_OFF: s_axi_rdata <= master_r;
          `MPP_CMD_OFF: s_axi_rdata <= '0;
          `MPP_STATUS_OFF: s_axi_rdata <= {21'h0, mst_r, err_code_r};
          `MPP_OFFSET_OFF: s_axi_rdata <= offset_r;
          `MPP_STMIN_OFF: s_axi_rdata <= stmin_r;
          `MPP_STMAX_OFF: s_axi_rdata <= stmax_r;
          `MPP_STPP_OFF: s_axi_rdata <= stmax_r - stmin_r;
          `MPP_MATSEL_OFF: s_axi_rdata <= {27'h0, matsel_r};
          `MPP_MATIDX_OFF: s_axi_rdata <= matidx_r;
          `MPP_MATVAL_OFF: s_axi_rdata <= mat_r[matsel_r];
          `MPP_DOUT0_OFF: s_axi_rdata <= out_d0;
          `MPP_DOUT1_OFF: s_axi_rdata <= out_d1;
          default: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Checks
  one_if_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !(eth_valid && ser_valid)) else $error("two interfaces active");
  mreset_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_mreset && mst_r == mpp_pkg::MPP_M_IDLE |=> offset_r == 32'h0000_0000)
    else $error("master reset left offset");
  timeout_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
    mst_r == mpp_pkg::MPP_M_WAIT ##1 mst_r == mpp_pkg::MPP_M_IDLE
    |-> err_code_r == `MPP_TIMEOUT_CODE && $stable(offset_r))
    else $error("timeout changed offset or missed code");
  master_take_a: assert property (@(posedge aclk) disable iff (!aresetn)
    mst_r == mpp_pkg::MPP_M_WAIT && ch0.out_valid && !meas_err_d_r && !zero_mode_r
    |=> offset_r == $past(master_r) - $past(ch0.out_val))
    else $error("offset not master minus capture");
  zero_take_a: assert property (@(posedge aclk) disable iff (!aresetn)
    mst_r == mpp_pkg::MPP_M_WAIT && ch0.out_valid && !meas_err_d_r && zero_mode_r
    |=> offset_r == -$past(ch0.out_val)) else $error("zero not applied");
  stat_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_stat |=> statcnt_r == 15'h0000 && stmin_r == 32'h0000_0000)
    else $error("statistics not restarted");
  wait_bound_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wait_r <= 32'(`MPP_MASTER_WAIT_CYC)) else $error("master wait overran");
  out_offset_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ch0.out_valid |=> out_d0 == $past(ch0.out_val) + $past(offset_r))
    else $error("offset missing on output");
  thick_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ch0.out_valid |=> out_thick == $past(ch1.out_val) - $past(ch0.out_val))
    else $error("thickness not from corrected values");
endmodule : mpp_top

// [src/mpp_defines.svh]
/*
  Constants for the measurement post-processing block: register offsets,
  field positions, reset values and timing counts.
  Assumes a 25 MHz aclk and a 32-bit AXI4-Lite register bus.
*/
`ifndef MPP_DEFINES_SVH
`define MPP_DEFINES_SVH

// Register byte offsets
`define MPP_CTRL_OFF 8'h00
`define MPP_SPIKE_OFF 8'h04
`define MPP_STATLEN_OFF 8'h08
`define MPP_MASTER_OFF 8'h0C
`define MPP_CMD_OFF 8'h10
`define MPP_STATUS_OFF 8'h14
`define MPP_OFFSET_OFF 8'h18
`define MPP_STMIN_OFF 8'h1C
`define MPP_STMAX_OFF 8'h20
`define MPP_STPP_OFF 8'h24
`define MPP_MATSEL_OFF 8'h28
`define MPP_MATIDX_OFF 8'h2C
`define MPP_MATVAL_OFF 8'h30
`define MPP_DOUT0_OFF 8'h34
`define MPP_DOUT1_OFF 8'h38

// CTRL fields
`define MPP_CTRL_SPIKE_EN 0
`define MPP_CTRL_IFSEL_LO 4
`define MPP_CTRL_BAUD_LO 8
`define MPP_CTRL_ITEMS_LO 16
// CMD bits (write one to act)
`define MPP_CMD_STAT_RST 0
`define MPP_CMD_MASTER 1
`define MPP_CMD_ZERO 2
`define MPP_CMD_MRESET 3
`define MPP_CMD_FACTORY 4

// Reset values
`define MPP_CTRL_RST 32'h0000_0000
`define MPP_SPIKE_RST 32'h0001_0A0A
`define MPP_STATLEN_RST 15'h0010
`define MPP_TIMEOUT_CODE 8'h20

// Limits
`define MPP_EVAL_MAX 10
`define MPP_CORR_MAX 100
`define MPP_STAT_MAX 16384
`define MPP_MAT_N 20
`define MPP_IDX_DEF 32'h0001_0000

// Master wait: 2 s at 40 ns per clock
`define MPP_CLK_NS 40
`define MPP_MASTER_WAIT_S 2
`define MPP_MASTER_WAIT_CYC ((`MPP_MASTER_WAIT_S * 1000000000) / `MPP_CLK_NS)

`endif

// [src/mpp_pkg.sv]
/*
  Types for the measurement post-processing block.
  Assumes the constants header is included by users.
*/
package mpp_pkg;
  typedef logic signed [31:0] mpp_dist_t;
  // Master sequencer states
  typedef enum logic [2:0] {
    MPP_M_IDLE = 3'b001,
    MPP_M_WAIT = 3'b010,
    MPP_M_DONE = 3'b100
  } mpp_mst_t;
  // Output interface selection
  typedef enum logic [1:0] {
    MPP_IF_ETH = 2'b01,
    MPP_IF_SER = 2'b10
  } mpp_if_t;
endpackage : mpp_pkg

// [src/mpp_spike_if.sv]
/*
  Interface carrying one distance channel into and out of a spike filter.
  Assumes a single aclk domain.
*/
`timescale 1ns/1ns
interface mpp_spike_if;
  logic in_valid;
  logic in_err;
  logic signed [31:0] in_val;
  logic out_valid;
  logic signed [31:0] out_val;
  modport filt (input in_valid, input in_err, input in_val, output out_valid, output out_val);
  modport user (output in_valid, output in_err, output in_val, input out_valid, input out_val);
endinterface : mpp_spike_if

// [src/mpp_spike.sv]
/*
  Spike filter for one distance channel: compares each valid value to the
  mean of the last N valid outputs, replaces out-of-band ones.
  Assumes configuration holds steady while values flow.
*/
`timescale 1ns/1ns
module mpp_spike (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Configuration
  input wire logic enable,
  input wire logic [3:0] eval_len,
  input wire logic [31:0] tol,
  input wire logic [6:0] corr_max,
  // Stream
  mpp_spike_if.filt s
);
  logic signed [31:0] hist_r [0:9];
  logic [3:0] fill_r;
  logic [6:0] run_r;
  logic signed [31:0] prev_r;
  logic signed [35:0] sum;
  logic signed [31:0] mean;
  logic signed [32:0] dev;
  logic [3:0] n_eff;
  logic spike;

  // Mean over valid history, window capped at ten
  always_comb begin
    sum = '0;
    n_eff = (fill_r < eval_len) ? fill_r : eval_len;
    for (int i = 0; i < 10; i++) begin
      if (4'(i) < n_eff) begin
        sum = sum + 36'(hist_r[i]);
      end
    end
    mean = (n_eff == 4'h0) ? s.in_val : 32'(sum / $signed({32'h0000_0000, n_eff}));
    dev = 33'(s.in_val) - 33'(mean);
    spike = enable && (n_eff != 4'h0) && (run_r < corr_max)
      && ((dev > $signed({1'b0, tol})) || (dev < -$signed({1'b0, tol})));
  end

  // History, run counter and output; errors pass raw to the output and skip history and run counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fill_r <= 4'h0;
      run_r <= 7'h00;
      prev_r <= '0;
      s.out_valid <= 1'b0;
      s.out_val <= '0;
      for (int i = 0; i < 10; i++) hist_r[i] <= '0;
    end else begin
      s.out_valid <= s.in_valid;
      if (s.in_valid && s.in_err) begin
        s.out_val <= s.in_val;
      end else if (s.in_valid) begin
        // Corrected value feeds history so runs build on it
        s.out_val <= spike ? prev_r : s.in_val;
        prev_r <= spike ? prev_r : s.in_val;
        run_r <= spike ? run_r + 7'h01 : 7'h00;
        for (int i = 9; i > 0; i--) hist_r[i] <= hist_r[i-1];
        hist_r[0] <= spike ? prev_r : s.in_val;
        if (fill_r < 4'd10) fill_r <= fill_r + 4'h1;
      end
    end
  end

  spike_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s.in_valid && !s.in_err && spike |=> s.out_valid && s.out_val == $past(prev_r))
    else $error("spike not replaced by previous value");
  run_cap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    run_r <= corr_max || !enable) else $error("correction run exceeds limit");
  err_pass_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s.in_valid && s.in_err |=> run_r == $past(run_r) && fill_r == $past(fill_r))
    else $error("error value altered filter state");
endmodule : mpp_spike

// [sim/mpp_src_model.sv]
/*
  Upstream distance source: hands one value pair per push to the block.
  Assumes the bench raises push for one cycle per value.
*/
`timescale 1ns/1ns
module mpp_src_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // From bench
  input wire logic push,
  input wire logic p_err,
  input wire logic [31:0] p_d0,
  input wire logic [31:0] p_d1,
  // To block
  output logic meas_valid,
  output logic meas_err,
  output logic [31:0] meas_d0,
  output logic [31:0] meas_d1
);
  // Idle data toggles, so a stale value never passes for a fresh one
  always_ff @(posedge aclk) begin
    meas_valid <= aresetn & push;
    meas_err <= aresetn & push & p_err;
    meas_d0 <= !aresetn ? 32'h0000_0000 : push ? p_d0 : ~meas_d0;
    meas_d1 <= !aresetn ? 32'h0000_0000 : push ? p_d1 : ~meas_d1;
  end
endmodule : mpp_src_model

// [sim/tb_top.sv]
/*
  Self-checking bench: AXI4-Lite master, stream source, output monitor.
  Assumes the downstream side is always ready.
*/
`timescale 1ns/1ns
`include "mpp_defines.svh"
module tb_top;
  typedef struct packed {logic [1:0] rt; logic er; logic [31:0] d0, d1;} mpp_exp_t;
  logic p_err = 1'b0;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] aw_a = 8'h00, ar_a = 8'h00, items;
  logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0, push = 1'b0;
  logic [31:0] w_d = 32'h0000_0000, p_d0 = 32'h0000_0000, p_d1 = 32'h0000_0000;
  logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, m_v, m_e, eth_v, ser_v, o_err;
  logic [1:0] b_resp, r_resp;
  logic [31:0] r_d, m_d0, m_d1, o_d0, o_d1, o_th, refr, rd;
  logic [2:0] o_baud, baud;
  logic [7:0] o_items;
  logic [31:0] in_v [6] = '{32'h64, 32'h64, 32'h64, 32'h1F4, 32'h258, 32'h2BC};
  logic [31:0] ex_v [6] = '{32'h64, 32'h64, 32'h64, 32'h64, 32'h64, 32'h2BC};
  mpp_exp_t exp_q [$];
  mpp_exp_t cur;
  int num_errors = 0;
  int cmp_count = 0;

  always #20 aclk = ~aclk;

  mpp_src_model src (.aclk(aclk), .aresetn(aresetn), .push(push), .p_err(p_err), .p_d0(p_d0),
    .p_d1(p_d1), .meas_valid(m_v), .meas_err(m_e), .meas_d0(m_d0), .meas_d1(m_d1));
  mpp_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v),
    .s_axi_awready(aw_rdy), .s_axi_wdata(w_d), .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v),
    .s_axi_wready(w_rdy), .s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
    .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy), .s_axi_rdata(r_d),
    .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_r), .meas_valid(m_v),
    .meas_err(m_e), .meas_d0(m_d0), .meas_d1(m_d1), .eth_valid(eth_v), .ser_valid(ser_v),
    .out_d0(o_d0), .out_d1(o_d1), .out_thick(o_th), .out_err(o_err), .out_items(o_items),
    .ser_baud(o_baud), .refr_index(refr));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("Compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  // Address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    aw_a <= a;
    w_d <= d;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    do begin
      @(posedge aclk);
      if (aw_v && aw_rdy) aw_v <= 1'b0;
      if (w_v && w_rdy) w_v <= 1'b0;
    end while (b_v !== 1'b1);
    b_r <= 1'b0;
    chk("bresp", 32'h0000_0000, {30'h0, b_resp});
  endtask : wr

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] er);
    @(posedge aclk);
    ar_a <= a;
    ar_v <= 1'b1;
    r_r <= 1'b1;
    do begin
      @(posedge aclk);
      if (ar_v && ar_rdy) ar_v <= 1'b0;
    end while (r_v !== 1'b1);
    r_r <= 1'b0;
    chk(nm, e, r_d);
    chk("rresp", {30'h0, er}, {30'h0, r_resp});
  endtask : rchk

  // Queue the expected sample only where an interface should carry it
  task automatic send(input logic [31:0] a, b, e0, e1, input logic [1:0] rt);
    @(posedge aclk);
    push <= 1'b1;
    p_d0 <= a;
    p_d1 <= b;
    if (rt != 2'b00) exp_q.push_back({rt, p_err, e0, e1});
  endtask : send

  task automatic idle(input int n);
    @(posedge aclk);
    push <= 1'b0;
    repeat (n) @(posedge aclk);
  endtask : idle

  // Monitor: oldest note against each sample that appears
  always @(posedge aclk) begin
    if (aresetn && (eth_v === 1'b1 || ser_v === 1'b1)) begin
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("BAD sample exp none got %h", o_d0);
      end else begin
        cur = exp_q.pop_front();
        chk("route", {30'h0, cur.rt}, {30'h0, ser_v, eth_v});
        chk("out_d0", cur.d0, o_d0);
        chk("out_d1", cur.d1, o_d1);
        chk("thick", cur.d1 - cur.d0, o_th);
        chk("out_err", {31'h0, cur.er}, {31'h0, o_err});
      end
    end
  end

  // Watchdog: whole run is a few hundred cycles
  initial begin
    repeat (5000) @(posedge aclk);
    num_errors++;
    tally_and_finish;
  end

  initial begin
    void'($urandom(79789));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rchk("spike", `MPP_SPIKE_OFF, 32'h0001_0A0A, 2'b00);
    rchk("statlen", `MPP_STATLEN_OFF, 32'h0000_0010, 2'b00);
    rchk("unmapped", 8'hFC, 32'h0000_0000, 2'b10);
    chk("refr", 32'h0001_0000, refr);
    // Entry three loaded and selected, then the factory reload
    wr(`MPP_MATSEL_OFF, 32'h0000_0003);
    wr(`MPP_MATVAL_OFF, 32'h0001_8000);
    wr(`MPP_MATIDX_OFF, 32'h0000_0003);
    idle(2);
    chk("refr", 32'h0001_8000, refr);
    wr(`MPP_CMD_OFF, 32'h0000_0010);
    idle(2);
    chk("refr", 32'h0001_0000, refr);
    items = 8'($urandom);
    baud = 3'($urandom);
    wr(`MPP_CTRL_OFF, {8'h00, items, 5'h00, baud, 2'b00, 2'b01, 4'h1});
    wr(`MPP_SPIKE_OFF, 32'h0002_0A02);
    chk("items", {24'h0, items}, {24'h0, o_items});
    chk("baud", {29'h0, baud}, {29'h0, o_baud});
    // Mean of two, tolerance 10, at most two replacements in a row
    for (int i = 0; i < 6; i++) begin
      send(in_v[i], in_v[i] + 32'h32, ex_v[i], ex_v[i] + 32'h32, 2'b01);
    end
    idle(6);
    // Error value passes raw and must not pull the mean up
    p_err <= 1'b1;
    send(32'h1388, 32'h13BA, 32'h1388, 32'h13BA, 2'b01);
    idle(1);
    p_err <= 1'b0;
    send(32'h190, 32'h1C2, 32'h190, 32'h1C2, 2'b01);
    idle(6);
    // Every interface selection, spike filter off
    for (int k = 0; k < 4; k++) begin
      wr(`MPP_CTRL_OFF, {8'h00, items, 5'h00, baud, 2'b00, 2'(k), 4'h0});
      send(32'h28, 32'h30, 32'h28, 32'h30, (k == 1 || k == 2) ? 2'(k) : 2'b00);
      idle(4);
    end
    wr(`MPP_CTRL_OFF, {8'h00, items, 5'h00, baud, 2'b00, 2'b01, 4'h0});
    // Restart: older, lower values must drop out of the statistics
    wr(`MPP_CMD_OFF, 32'h0000_0001);
    send(32'h320, 32'h330, 32'h320, 32'h330, 2'b01);
    send(32'h300, 32'h310, 32'h300, 32'h310, 2'b01);
    send(32'h3A0, 32'h3B0, 32'h3A0, 32'h3B0, 2'b01);
    idle(4);
    rchk("stmin", `MPP_STMIN_OFF, 32'h0000_0300, 2'b00);
    rchk("stmax", `MPP_STMAX_OFF, 32'h0000_03A0, 2'b00);
    rchk("stpp", `MPP_STPP_OFF, 32'h0000_00A0, 2'b00);
    wr(`MPP_MASTER_OFF, 32'h0000_03E8);
    wr(`MPP_CMD_OFF, 32'h0000_0002);
    send(32'h12C, 32'h15E, 32'h12C, 32'h15E, 2'b01);
    idle(4);
    rchk("offset", `MPP_OFFSET_OFF, 32'h0000_02BC, 2'b00);
    send(32'h1F4, 32'h230, 32'h4B0, 32'h4EC, 2'b01);
    idle(4);
    wr(`MPP_CMD_OFF, 32'h0000_0008);
    rchk("offset", `MPP_OFFSET_OFF, 32'h0000_0000, 2'b00);
    wr(`MPP_CMD_OFF, 32'h0000_0004);
    send(32'hC8, 32'h104, 32'hC8, 32'h104, 2'b01);
    idle(4);
    rchk("offset", `MPP_OFFSET_OFF, 32'hFFFF_FF38, 2'b00);
    send(32'h1C2, 32'h1F4, 32'hFA, 32'h12C, 2'b01);
    idle(4);
    chk("pending", 32'h0000_0000, 32'(exp_q.size()));
    tally_and_finish;
  end
endmodule : tb_top
